// ===== spss_host_model.sv
// spss_host_model: host that watches status pins and feeds serial data
module spss_host_model (
  input wire logic clk, // system clock
  input wire logic srst, // sync reset
  input wire logic sclk_pin, // serial clock pin
  input wire logic lock_pin, // lock detector pin
  input wire logic [31:0] tx_pattern, // bits to send
  output logic tx_data, // transmit data pin
  output int lock_edges // lock rises seen
);
  logic sclk_prev_q, lock_prev_q;
  logic [4:0] idx_q;
  wire logic fall_w;
  // a real host moves data at the pin fall itself, not one sample later
  assign fall_w = !sclk_pin && sclk_prev_q;
  // lock taken from edges, not one level sample
  always_ff @(posedge clk) begin
    lock_prev_q <= lock_pin;
    if (srst) lock_edges <= 0;
    else if (lock_pin && !lock_prev_q) lock_edges <= lock_edges + 1;
  end
  // move data on falls so it is steady at the rise
  always_ff @(posedge clk) begin
    sclk_prev_q <= sclk_pin;
    if (srst) idx_q <= '0;
    else if (fall_w) idx_q <= idx_q + 5'h01;
  end
  assign tx_data = tx_pattern[idx_q + 5'(fall_w)];
endmodule // spss_host_model

// ===== spss_pin_sel.sv
// spss_pin_sel: per pin signal selection with optional inversion
module spss_pin_sel (
  input wire logic clk, // system clock
  input wire logic srst, // synchronous reset, active high
  input spss_pkg::spss_sig_s sig, // selectable signals
  input spss_pkg::spss_pcfg_s [spss_pkg::NPINS-1:0] cfg, // per pin select and invert
  output logic [spss_pkg::NPINS-1:0] pin // registered pin levels
);

  genvar g;
  generate
    for (g = 0; g < spss_pkg::NPINS; g++) begin : g_pin
      wire logic [5:0] sel_w;
      wire logic raw_w;
      wire logic out_w;
      // unknown codes drive low before inversion
      assign sel_w = cfg[g].sel;
      assign raw_w = (sel_w == spss_pkg::SEL_FRAME) ? sig.frame :
                     (sel_w == spss_pkg::SEL_PKT_OK) ? sig.pkt_ok :
                     (sel_w == spss_pkg::SEL_PQ_REACHED) ? sig.pq_reached :
                     (sel_w == spss_pkg::SEL_CLEAR_CH) ? sig.clear_ch :
                     (sel_w == spss_pkg::SEL_PLL_LOCK) ? sig.pll_lock :
                     (sel_w == spss_pkg::SEL_SER_CLK) ? sig.ser_clk :
                     (sel_w == spss_pkg::SEL_SYNC_DATA) ? sig.sync_data :
                     (sel_w == spss_pkg::SEL_ASYNC_DATA) ? sig.async_data :
                     (sel_w == spss_pkg::SEL_CARRIER) ? sig.carrier :
                     (sel_w == spss_pkg::SEL_CRC_OK) ? sig.crc_ok : 1'b0;
      assign out_w = raw_w ^ cfg[g].invert;
      // one register stage so the pin is glitch free
      always_ff @(posedge clk) begin
        if (srst) begin
          pin[g] <= 1'b0;
        end else begin
          pin[g] <= out_w;
        end
      end
    end
  endgenerate

endmodule // spss_pin_sel

// ===== spss_pkg.sv
// spss_pkg: shared constants, selection codes and pin config and signal struct types for the status pin block
package spss_pkg;

  // number of status output pins
  localparam int NPINS = 3;

  // register byte offsets on the apb bus
  localparam logic [7:0] OFF_PIN_CFG0 = 8'h00;
  localparam logic [7:0] OFF_PIN_CFG1 = 8'h04;
  localparam logic [7:0] OFF_PIN_CFG2 = 8'h08;
  localparam logic [7:0] OFF_THRESH = 8'h0C;
  localparam logic [7:0] OFF_STATUS = 8'h10;
  localparam logic [7:0] OFF_IRQ_STAT = 8'h14;
  localparam logic [7:0] OFF_IRQ_CLR = 8'h18;
  localparam logic [7:0] OFF_IRQ_EN = 8'h1C;

  // field positions
  localparam int CFG_SEL_LSB = 0;
  localparam int CFG_INV_BIT = 6;
  localparam int THR_PQT_LSB = 8'd0;
  localparam int THR_RSSI_LSB = 8;
  localparam int THR_CCM_LSB = 16;
  localparam int THR_SER_BIT = 24;

  // reset values
  localparam logic [6:0] PIN_CFG_RST = 7'h00;
  localparam logic [7:0] PQT_RST = 8'h00;
  localparam logic [7:0] RSSI_THR_RST = 8'h00;
  localparam logic [1:0] CCM_RST = 2'h0;
  localparam logic [3:0] IRQ_EN_RST = 4'h0;

  // selection codes handled by this block
  localparam logic [5:0] SEL_FRAME = 6'h06;
  localparam logic [5:0] SEL_PKT_OK = 6'h07;
  localparam logic [5:0] SEL_PQ_REACHED = 6'h08;
  localparam logic [5:0] SEL_CLEAR_CH = 6'h09;
  localparam logic [5:0] SEL_PLL_LOCK = 6'h0A;
  localparam logic [5:0] SEL_SER_CLK = 6'h0B;
  localparam logic [5:0] SEL_SYNC_DATA = 6'h0C;
  localparam logic [5:0] SEL_ASYNC_DATA = 6'h0D;
  localparam logic [5:0] SEL_CARRIER = 6'h0E;
  localparam logic [5:0] SEL_CRC_OK = 6'h0F;

  // clear channel mode encodings
  localparam logic [1:0] CCM_ALWAYS = 2'h0;
  localparam logic [1:0] CCM_RSSI = 2'h1;
  localparam logic [1:0] CCM_NOT_RX_PKT = 2'h2;
  localparam logic [1:0] CCM_BOTH = 2'h3;

  // interrupt status bit positions
  localparam int IRQ_SYNC = 0;
  localparam int IRQ_PKT_OK = 1;
  localparam int IRQ_LOCK = 2;
  localparam int IRQ_CARRIER = 3;

  // timing: serial clock period and the derived half period in system clocks
  localparam int CLK_PERIOD_NS = 20;
  localparam int SCLK_PERIOD_NS = 160;
  localparam int SCLK_HALF_CYC = SCLK_PERIOD_NS / (2 * CLK_PERIOD_NS);

  // per pin configuration
  typedef struct packed {
    logic invert;
    logic [5:0] sel;
  } spss_pcfg_s;

  // every selectable internal signal
  typedef struct packed {
    logic frame;
    logic pkt_ok;
    logic pq_reached;
    logic clear_ch;
    logic pll_lock;
    logic ser_clk;
    logic sync_data;
    logic async_data;
    logic carrier;
    logic crc_ok;
  } spss_sig_s;

endpackage

// ===== spss_properties.sv
// spss_properties: port-level assertions for the status pin block
module spss_properties (
  input wire logic CLK, // clock
  input wire logic SRST, // reset
  input wire logic PSEL, // apb
  input wire logic PENABLE, // apb
  input wire logic PWRITE, // apb
  input wire logic [7:0] PADDR, // apb
  input wire logic [31:0] PWDATA, // apb
  input wire logic PREADY, // apb
  input wire logic SYNC_FOUND, // event
  input wire logic PKT_END, // event
  input wire logic CRC_DONE, // event
  input wire logic CRC_MATCH, // result
  input wire logic RX_FIRST_READ, // event
  input wire logic RX_ENTER, // event
  input wire logic [2:0] STATUS_OUTPUT_PIN, // pins
  input wire logic RX_BIT_TAKE, // pulse
  input wire logic TX_BIT_STB // pulse
);
  spss_pkg::spss_pcfg_s c0_q;
  logic wr0, p0, m_fr, m_pk, m_crc, m_bad;
  // pin 0 config shadow; only committed writes count
  assign wr0 = PSEL && PENABLE && PREADY && PWRITE && PADDR == spss_pkg::OFF_PIN_CFG0;
  assign p0 = STATUS_OUTPUT_PIN[0];
  assign m_fr = c0_q == {1'b0, spss_pkg::SEL_FRAME};
  assign m_pk = c0_q == {1'b0, spss_pkg::SEL_PKT_OK};
  assign m_crc = c0_q == {1'b0, spss_pkg::SEL_CRC_OK};
  assign m_bad = c0_q.sel < 6'h06 || c0_q.sel > 6'h0F;
  // shadow register, cleared with the design
  always_ff @(posedge CLK) begin
    if (SRST) c0_q <= '0;
    else if (wr0) c0_q <= PWDATA[6:0];
  end
  default clocking cb @(posedge CLK); endclocking
  default disable iff (SRST);
  a_ready_wait: assert property (PSEL && $rose(PENABLE) |=> PREADY ##1 !PREADY)
    else $error("ready not a single pulse after one wait");
  a_frame_rise: assert property (m_fr && SYNC_FOUND |-> ##2 p0)
    else $error("frame pin did not rise");
  a_frame_fall: assert property (m_fr && PKT_END && !SYNC_FOUND |-> ##2 !p0)
    else $error("frame pin did not fall");
  a_pkt_clear: assert property (m_pk && RX_FIRST_READ && !CRC_DONE |-> ##2 !p0)
    else $error("packet pin not cleared by read");
  a_crc_follow: assert property (m_crc && CRC_DONE && !RX_ENTER |-> ##2 p0 == $past(CRC_MATCH, 2))
    else $error("checksum pin wrong");
  a_crc_clear: assert property (m_crc && RX_ENTER && !CRC_DONE |-> ##2 !p0)
    else $error("checksum pin not cleared");
  a_bad_code: assert property (m_bad |=> p0 == $past(c0_q.invert))
    else $error("unsupported code pin wrong");
  a_take_gap: assert property (RX_BIT_TAKE |=> !RX_BIT_TAKE [*7])
    else $error("receive bits too close");
  a_stb_gap: assert property (TX_BIT_STB |=> !TX_BIT_STB [*7])
    else $error("transmit samples too close");
  c_frame: cover property (m_fr && SYNC_FOUND);
  c_crc_clr: cover property (m_crc && RX_ENTER);
  c_take: cover property (RX_BIT_TAKE);
endmodule // spss_properties

bind spss_top spss_properties u_props (.CLK(CLK), .SRST(SRST), .PSEL(PSEL),
  .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PREADY(PREADY),
  .SYNC_FOUND(SYNC_FOUND), .PKT_END(PKT_END), .CRC_DONE(CRC_DONE), .CRC_MATCH(CRC_MATCH),
  .RX_FIRST_READ(RX_FIRST_READ), .RX_ENTER(RX_ENTER), .STATUS_OUTPUT_PIN(STATUS_OUTPUT_PIN),
  .RX_BIT_TAKE(RX_BIT_TAKE), .TX_BIT_STB(TX_BIT_STB));

// ===== spss_ser_clk.sv
// spss_ser_clk: serial clock divider, receive data launch and transmit data capture
module spss_ser_clk (
  input wire logic clk, // system clock
  input wire logic srst, // synchronous reset, active high
  input wire logic run, // serial clock enable
  input wire logic rx_mode, // radio in receive
  input wire logic tx_mode, // radio in transmit
  input wire logic rx_bit_in, // next received bit from the demodulator
  input wire logic host_tx_pin, // host transmit data pin, asynchronous
  output logic ser_clk, // serial clock, internal polarity
  output logic rx_data, // synchronous receive data
  output logic rx_bit_take, // pulse: rx_bit_in was consumed
  output logic tx_bit, // captured transmit bit
  output logic tx_bit_stb // pulse: tx_bit is new
);

  localparam logic [2:0] HALF_M1 = 3'(spss_pkg::SCLK_HALF_CYC - 1);

  logic [2:0] cnt_q;
  logic [2:0] cnt_d;
  logic sync1_q;
  logic sync2_q;
  wire logic half_w;
  wire logic rise_w;
  wire logic fall_w;

  // divider: one half period of the serial clock per wrap
  assign half_w = run && (cnt_q == HALF_M1);
  assign rise_w = half_w && !ser_clk;
  assign fall_w = half_w && ser_clk;
  assign cnt_d = (!run || half_w) ? 3'h0 : cnt_q + 3'h1;

  // counter and clock; clock parks low while stopped
  always_ff @(posedge clk) begin
    if (srst) begin
      cnt_q <= 3'h0;
      ser_clk <= 1'b0;
    end else begin
      cnt_q <= cnt_d;
      ser_clk <= run ? (ser_clk ^ half_w) : 1'b0;
    end
  end

  // host pin passes two flops before use
  always_ff @(posedge clk) begin
    if (srst) begin
      sync1_q <= 1'b0;
      sync2_q <= 1'b0;
    end else begin
      sync1_q <= host_tx_pin;
      sync2_q <= sync1_q;
    end
  end

  // receive data changes on falling edge
  always_ff @(posedge clk) begin
    if (srst) begin
      rx_data <= 1'b0;
      rx_bit_take <= 1'b0;
    end else begin
      rx_bit_take <= fall_w && rx_mode;
      if (fall_w && rx_mode) begin
        rx_data <= rx_bit_in;
      end
    end
  end

  // transmit data sampled on rising edge
  always_ff @(posedge clk) begin
    if (srst) begin
      tx_bit <= 1'b0;
      tx_bit_stb <= 1'b0;
    end else begin
      tx_bit_stb <= rise_w && tx_mode;
      if (rise_w && tx_mode) begin
        tx_bit <= sync2_q;
      end
    end
  end

endmodule // spss_ser_clk

// ===== spss_top.sv
// spss_top: status pin signal generation, selection and apb register file
//
// Implementation choices: the APB interface to the registers and the register offsets.
module spss_top (
  input wire logic CLK, // system clock, 50 MHz
  input wire logic SRST, // synchronous reset, active high
  input wire logic PSEL, // apb select
  input wire logic PENABLE, // apb enable
  input wire logic PWRITE, // apb direction
  input wire logic [7:0] PADDR, // apb byte address
  input wire logic [31:0] PWDATA, // apb write data
  output logic [31:0] PRDATA, // apb read data
  output logic PREADY, // apb ready
  output logic PSLVERR, // apb error on unmapped address
  input wire logic SYNC_FOUND, // pulse: sync word sent or received
  input wire logic PKT_END, // pulse: packet finished
  input wire logic ADDR_REJECT, // pulse: address filter rejected packet
  input wire logic RXBUF_OVF, // pulse: receive buffer overflow
  input wire logic TXBUF_UNF, // pulse: transmit buffer underflow
  input wire logic CRC_DONE, // pulse: checksum compared
  input wire logic CRC_MATCH, // comparison result, valid with CRC_DONE
  input wire logic RX_FIRST_READ, // pulse: host read first receive byte
  input wire logic RX_ENTER, // pulse: receive entered or restarted
  input wire logic RX_MODE, // level: radio receiving
  input wire logic TX_MODE, // level: radio transmitting
  input wire logic [7:0] PREAMBLE_QUALITY_INDICATOR, // measured preamble quality
  input wire logic [7:0] RSSI, // received signal strength
  input wire logic PLL_LOCK, // lock detector, asynchronous
  input wire logic RX_SER_BIT, // next demodulated bit, synchronous mode
  input wire logic RX_ASYNC_BIT, // raw demodulated data, asynchronous mode
  input wire logic HOST_TX_DATA, // host transmit data pin, asynchronous
  output logic [2:0] STATUS_OUTPUT_PIN, // status output pins
  output logic RX_BIT_TAKE, // pulse: RX_SER_BIT consumed
  output logic TX_BIT, // captured host transmit bit
  output logic TX_BIT_STB, // pulse: TX_BIT updated
  output logic IRQ // level interrupt
);

  // configuration registers
  spss_pkg::spss_pcfg_s [spss_pkg::NPINS-1:0] pcfg_q;
  logic [7:0] preamble_quality_threshold_q;
  logic [7:0] rssi_thr_q;
  logic [1:0] clear_channel_mode_select_q;
  logic ser_run_q;
  logic [3:0] irq_stat_q;
  logic [3:0] irq_stat_d;
  logic [3:0] irq_en_q;

  // internal signal state
  logic frame_q;
  logic frame_d;
  logic pkt_ok_q;
  logic pkt_ok_d;
  logic crc_ok_q;
  logic crc_ok_d;
  logic pq_q;
  logic clear_q;
  logic carrier_q;
  logic lock_s1_q;
  logic lock_s2_q;
  logic lock_prev_q;
  logic carrier_prev_q;
  logic async_q;

  // bus response state
  logic pready_q;
  logic [31:0] prdata_q;
  logic pslverr_q;

  wire logic ser_clk_w;
  wire logic rx_data_w;
  spss_pkg::spss_sig_s sig_w;

  // apb decode; access takes one wait cycle so all outputs come from flops
  wire logic acc_w;
  wire logic commit_w;
  wire logic wr_w;
  wire logic hit_cfg0_w;
  wire logic hit_cfg1_w;
  wire logic hit_cfg2_w;
  wire logic hit_thr_w;
  wire logic hit_stat_w;
  wire logic hit_istat_w;
  wire logic hit_iclr_w;
  wire logic hit_ien_w;
  wire logic mapped_w;
  wire logic [31:0] rdata_w;
  wire logic [3:0] clr_w;

  assign acc_w = PSEL && PENABLE;
  assign commit_w = acc_w && pready_q;
  assign wr_w = commit_w && PWRITE;
  assign hit_cfg0_w = (PADDR == spss_pkg::OFF_PIN_CFG0);
  assign hit_cfg1_w = (PADDR == spss_pkg::OFF_PIN_CFG1);
  assign hit_cfg2_w = (PADDR == spss_pkg::OFF_PIN_CFG2);
  assign hit_thr_w = (PADDR == spss_pkg::OFF_THRESH);
  assign hit_stat_w = (PADDR == spss_pkg::OFF_STATUS);
  assign hit_istat_w = (PADDR == spss_pkg::OFF_IRQ_STAT);
  assign hit_iclr_w = (PADDR == spss_pkg::OFF_IRQ_CLR);
  assign hit_ien_w = (PADDR == spss_pkg::OFF_IRQ_EN);
  assign mapped_w = hit_cfg0_w || hit_cfg1_w || hit_cfg2_w || hit_thr_w ||
                    hit_stat_w || hit_istat_w || hit_iclr_w || hit_ien_w;

  // read mux; clear register reads as zero, reserved bits read zero
  assign rdata_w = hit_cfg0_w ? {25'h0, pcfg_q[0]} :
                   hit_cfg1_w ? {25'h0, pcfg_q[1]} :
                   hit_cfg2_w ? {25'h0, pcfg_q[2]} :
                   hit_thr_w ? {7'h0, ser_run_q, 6'h0, clear_channel_mode_select_q,
                                rssi_thr_q, preamble_quality_threshold_q} :
                   hit_stat_w ? {22'h0, sig_w} :
                   hit_istat_w ? {28'h0, irq_stat_q} :
                   hit_ien_w ? {28'h0, irq_en_q} : 32'h0;

  // bus answer: ready high in the second access cycle, for one cycle
  always_ff @(posedge CLK) begin
    if (SRST) begin
      pready_q <= 1'b0;
      prdata_q <= 32'h0;
      pslverr_q <= 1'b0;
    end else begin
      pready_q <= acc_w && !pready_q;
      prdata_q <= (acc_w && !pready_q && !PWRITE) ? rdata_w : prdata_q;
      pslverr_q <= acc_w && !pready_q && !mapped_w;
    end
  end

  // pin configuration writes take effect only at the committing edge
  always_ff @(posedge CLK) begin
    if (SRST) begin
      pcfg_q <= {spss_pkg::NPINS{spss_pkg::PIN_CFG_RST}};
    end else if (wr_w) begin
      if (hit_cfg0_w) begin
        pcfg_q[0] <= PWDATA[spss_pkg::CFG_INV_BIT:spss_pkg::CFG_SEL_LSB];
      end else if (hit_cfg1_w) begin
        pcfg_q[1] <= PWDATA[spss_pkg::CFG_INV_BIT:spss_pkg::CFG_SEL_LSB];
      end else if (hit_cfg2_w) begin
        pcfg_q[2] <= PWDATA[spss_pkg::CFG_INV_BIT:spss_pkg::CFG_SEL_LSB];
      end
    end
  end

  // thresholds, clear channel mode and serial clock enable
  always_ff @(posedge CLK) begin
    if (SRST) begin
      preamble_quality_threshold_q <= spss_pkg::PQT_RST;
      rssi_thr_q <= spss_pkg::RSSI_THR_RST;
      clear_channel_mode_select_q <= spss_pkg::CCM_RST;
      ser_run_q <= 1'b0;
    end else if (wr_w && hit_thr_w) begin
      preamble_quality_threshold_q <= PWDATA[spss_pkg::THR_PQT_LSB +: 8];
      rssi_thr_q <= PWDATA[spss_pkg::THR_RSSI_LSB +: 8];
      clear_channel_mode_select_q <= PWDATA[spss_pkg::THR_CCM_LSB +: 2];
      ser_run_q <= PWDATA[spss_pkg::THR_SER_BIT];
    end
  end

  // frame flag set on sync, set beats any clear
  // receive reject or overflow ends it early
  assign frame_d = SYNC_FOUND ? 1'b1 :
                   (PKT_END || (RX_MODE && (ADDR_REJECT || RXBUF_OVF)) ||
                    (TX_MODE && TXBUF_UNF)) ? 1'b0 : frame_q;

  // good packet flag, set beats the read clear
  assign pkt_ok_d = (CRC_DONE && CRC_MATCH) ? 1'b1 :
                    RX_FIRST_READ ? 1'b0 : pkt_ok_q;

  // last comparison result, cleared by receive entry unless a match lands
  assign crc_ok_d = (CRC_DONE && CRC_MATCH) ? 1'b1 :
                    (CRC_DONE || RX_ENTER) ? 1'b0 : crc_ok_q;

  // framing and checksum flags
  always_ff @(posedge CLK) begin
    if (SRST) begin
      frame_q <= 1'b0;
      pkt_ok_q <= 1'b0;
      crc_ok_q <= 1'b0;
    end else begin
      frame_q <= frame_d;
      pkt_ok_q <= pkt_ok_d;
      crc_ok_q <= crc_ok_d;
    end
  end

  // threshold comparisons; registered so a comparator glitch never hits a pin
  wire logic rssi_low_w;
  wire logic rx_pkt_w;
  wire logic clear_w;
  assign rssi_low_w = (RSSI < rssi_thr_q);
  assign rx_pkt_w = RX_MODE && frame_q;
  assign clear_w = (clear_channel_mode_select_q == spss_pkg::CCM_ALWAYS) ? 1'b1 :
                   (clear_channel_mode_select_q == spss_pkg::CCM_RSSI) ? rssi_low_w :
                   (clear_channel_mode_select_q == spss_pkg::CCM_NOT_RX_PKT) ? !rx_pkt_w :
                   (rssi_low_w && !rx_pkt_w);

  // level indicators
  always_ff @(posedge CLK) begin
    if (SRST) begin
      pq_q <= 1'b0;
      clear_q <= 1'b0;
      carrier_q <= 1'b0;
      async_q <= 1'b0;
    end else begin
      pq_q <= (PREAMBLE_QUALITY_INDICATOR > preamble_quality_threshold_q);
      clear_q <= clear_w;
      carrier_q <= (RSSI > rssi_thr_q);
      async_q <= RX_ASYNC_BIT;
    end
  end

  // lock detector comes from another domain: two flops, then edge history
  always_ff @(posedge CLK) begin
    if (SRST) begin
      lock_s1_q <= 1'b0;
      lock_s2_q <= 1'b0;
      lock_prev_q <= 1'b0;
      carrier_prev_q <= 1'b0;
    end else begin
      lock_s1_q <= PLL_LOCK;
      lock_s2_q <= lock_s1_q;
      lock_prev_q <= lock_s2_q;
      carrier_prev_q <= carrier_q;
    end
  end

  // serial clock generation and data timing
  spss_ser_clk u_ser (
    .clk(CLK),
    .srst(SRST),
    .run(ser_run_q),
    .rx_mode(RX_MODE),
    .tx_mode(TX_MODE),
    .rx_bit_in(RX_SER_BIT),
    .host_tx_pin(HOST_TX_DATA),
    .ser_clk(ser_clk_w),
    .rx_data(rx_data_w),
    .rx_bit_take(RX_BIT_TAKE),
    .tx_bit(TX_BIT),
    .tx_bit_stb(TX_BIT_STB)
  );

  // gather selectable signals
  assign sig_w.frame = frame_q;
  assign sig_w.pkt_ok = pkt_ok_q;
  assign sig_w.pq_reached = pq_q;
  assign sig_w.clear_ch = clear_q;
  assign sig_w.pll_lock = lock_s2_q;
  assign sig_w.ser_clk = ser_clk_w;
  assign sig_w.sync_data = rx_data_w;
  assign sig_w.async_data = async_q;
  assign sig_w.carrier = carrier_q;
  assign sig_w.crc_ok = crc_ok_q;

  // per pin selection and inversion
  spss_pin_sel u_sel (
    .clk(CLK),
    .srst(SRST),
    .sig(sig_w),
    .cfg(pcfg_q),
    .pin(STATUS_OUTPUT_PIN)
  );

  // sticky interrupt events; a new event beats a clear in the same cycle
  wire logic [3:0] ev_w;
  assign ev_w[spss_pkg::IRQ_SYNC] = SYNC_FOUND;
  assign ev_w[spss_pkg::IRQ_PKT_OK] = CRC_DONE && CRC_MATCH;
  // lock taken from its rising edge
  assign ev_w[spss_pkg::IRQ_LOCK] = lock_s2_q && !lock_prev_q;
  assign ev_w[spss_pkg::IRQ_CARRIER] = carrier_q && !carrier_prev_q;
  assign clr_w = (wr_w && hit_iclr_w) ? PWDATA[3:0] : 4'h0;
  assign irq_stat_d = (irq_stat_q & ~clr_w) | ev_w;

  // interrupt status, enable and output
  always_ff @(posedge CLK) begin
    if (SRST) begin
      irq_stat_q <= 4'h0;
      irq_en_q <= spss_pkg::IRQ_EN_RST;
      IRQ <= 1'b0;
    end else begin
      irq_stat_q <= irq_stat_d;
      irq_en_q <= (wr_w && hit_ien_w) ? PWDATA[3:0] : irq_en_q;
      IRQ <= |(irq_stat_d & ((wr_w && hit_ien_w) ? PWDATA[3:0] : irq_en_q));
    end
  end

  // bus outputs straight from their flops
  assign PRDATA = prdata_q;
  assign PREADY = pready_q;
  assign PSLVERR = pslverr_q;

endmodule // spss_top

// ===== testbench.sv
// testbench: self-checking bench for the status pin block
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk, srst, psel, penable, pwrite, pready, pslverr, err, irq, below;
  logic [7:0] paddr, preamble_quality_indicator, rssi, ev;
  logic [31:0] pwdata, prdata, rd, thr, pattern;
  logic crc_match, rx_mode, tx_mode, pll_lock, rx_ser, rx_async, host_tx;
  logic rx_take, tx_bit, tx_stb, ser_chk, prev_clk, prev_dat, rx_exp;
  logic [2:0] pins, inv, exp_p;
  int num_errors, checks, cyc, edges, host_edges, takes;
  // frame end causes and the {rx, tx} mode beside each
  localparam logic [7:0] CAUSE [5] = '{8'h02, 8'h04, 8'h08, 8'h10, 8'h10};
  localparam logic [1:0] MODE [5] = '{2'b00, 2'b10, 2'b10, 2'b01, 2'b10};

  spss_top dut (.CLK(clk), .SRST(srst), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
    .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
    .SYNC_FOUND(ev[0]), .PKT_END(ev[1]), .ADDR_REJECT(ev[2]), .RXBUF_OVF(ev[3]),
    .TXBUF_UNF(ev[4]), .CRC_DONE(ev[5]), .CRC_MATCH(crc_match), .RX_FIRST_READ(ev[6]),
    .RX_ENTER(ev[7]), .RX_MODE(rx_mode), .TX_MODE(tx_mode), .PREAMBLE_QUALITY_INDICATOR(preamble_quality_indicator),
    .RSSI(rssi), .PLL_LOCK(pll_lock), .RX_SER_BIT(rx_ser), .RX_ASYNC_BIT(rx_async),
    .HOST_TX_DATA(host_tx), .STATUS_OUTPUT_PIN(pins), .RX_BIT_TAKE(rx_take),
    .TX_BIT(tx_bit), .TX_BIT_STB(tx_stb), .IRQ(irq));
  spss_host_model host (.clk(clk), .srst(srst), .sclk_pin(pins[1]), .lock_pin(pins[0]),
    .tx_pattern(pattern), .tx_data(host_tx), .lock_edges(host_edges));

  // 50 MHz system clock
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic results;
    $display("checks %0d errors %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  // one transfer; waits for ready, then an idle edge so psel never flips twice
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1) @(posedge clk);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask

  task automatic pin(input int i, input logic [6:0] c);
    apb(1'b1, 8'(4 * i), {25'h0, c});
  endtask

  // one-cycle event pulse, then time for flag and pin
  task automatic pulse(input logic [7:0] m);
    ev <= m;
    @(posedge clk);
    ev <= 8'h00;
    repeat (3) @(posedge clk);
  endtask

  // frame pin level expected after an end cause in a mode
  function automatic logic frame_after(input logic [7:0] c, input logic [1:0] m);
    if (c == 8'h02) return 1'b0;
    if (c != 8'h10) return !m[1];
    return !m[0];
  endfunction

  // serial monitors, receive bit feed and the hang limit
  always @(posedge clk) begin
    cyc++;
    if (rx_take) rx_ser <= 1'($urandom);
    if (rx_take) takes++;
    // the bit just consumed is what the pin will show at the next fall
    if (rx_take) rx_exp <= rx_ser;
    if (ser_chk && tx_stb) check(32'(tx_bit), 32'(host_tx));
    if (ser_chk && !pins[1] && prev_clk) check(32'(pins[2]), 32'(rx_exp));
    else if (ser_chk) check(32'(pins[2]), 32'(prev_dat));
    prev_clk <= pins[1];
    prev_dat <= pins[2];
    if (cyc > 5000) begin
      num_errors++;
      results();
    end
  end

  initial begin
    {psel, penable, pwrite, paddr, pwdata, ev, preamble_quality_indicator, rssi} = '0;
    {crc_match, rx_mode, tx_mode, pll_lock, rx_ser, rx_async, pattern} = '0;
    {num_errors, checks, cyc, takes, ser_chk} = '0;
    srst = 1'b1;
    void'($urandom(32'hCDB3));
    repeat (8) @(posedge clk);
    srst <= 1'b0;
    @(posedge clk);
    // reset values; status skipped as clear channel idles high
    for (int a = 0; a < 8; a++) begin
      apb(1'b0, 8'(4 * a), 32'h0);
      if (a != 4) check(rd, 32'h0);
    end
    apb(1'b0, 8'h20, 32'h0);
    check(32'(err), 32'h1);
    // interrupt raised, masked, cleared
    apb(1'b1, spss_pkg::OFF_IRQ_EN, 32'h1);
    pulse(8'h01);
    check(32'(irq), 32'h1);
    apb(1'b1, spss_pkg::OFF_IRQ_EN, 32'h0);
    check(32'(irq), 32'h0);
    apb(1'b0, spss_pkg::OFF_IRQ_STAT, 32'h0);
    check(rd, 32'h1);
    apb(1'b1, spss_pkg::OFF_IRQ_CLR, 32'h1);
    apb(1'b0, spss_pkg::OFF_IRQ_STAT, 32'h0);
    check(rd, 32'h0);
    // frame pin per end cause and mode
    pin(0, {1'b0, spss_pkg::SEL_FRAME});
    for (int k = 0; k < 5; k++) begin
      {rx_mode, tx_mode} <= MODE[k];
      pulse(8'h01);
      check(32'(pins[0]), 32'h1);
      pulse(CAUSE[k]);
      check(32'(pins[0]), 32'(frame_after(CAUSE[k], MODE[k])));
    end
    pulse(8'h02);
    // good packet flag cleared by first read, checksum flag by receive entry
    pin(0, {1'b0, spss_pkg::SEL_PKT_OK});
    crc_match <= 1'b1;
    pulse(8'h22);
    check(32'(pins[0]), 32'h1);
    pulse(8'h40);
    check(32'(pins[0]), 32'h0);
    pin(0, {1'b0, spss_pkg::SEL_CRC_OK});
    pulse(8'h20);
    check(32'(pins[0]), 32'h1);
    pulse(8'h80);
    check(32'(pins[0]), 32'h0);
    pulse(8'h20);
    crc_match <= 1'b0;
    pulse(8'h20);
    check(32'(pins[0]), 32'h0);
    // compares with random invert; frame idle
    for (int k = 0; k < 12; k++) begin
      inv = 3'($urandom);
      thr = $urandom & 32'h0003_FFFF;
      pin(0, {inv[0], spss_pkg::SEL_PQ_REACHED});
      pin(1, {inv[1], spss_pkg::SEL_CLEAR_CH});
      pin(2, {inv[2], spss_pkg::SEL_CARRIER});
      apb(1'b1, spss_pkg::OFF_THRESH, thr);
      preamble_quality_indicator <= (k < 2) ? thr[7:0] : 8'($urandom);
      rssi <= (k < 4) ? thr[15:8] : 8'($urandom);
      rx_mode <= 1'($urandom);
      repeat (3) @(posedge clk);
      below = rssi < thr[15:8];
      exp_p[0] = inv[0] ^ (preamble_quality_indicator > thr[7:0]);
      exp_p[1] = inv[1] ^ (thr[16] ? below : 1'b1);
      exp_p[2] = inv[2] ^ (rssi > thr[15:8]);
      check(32'(pins), 32'(exp_p));
    end
    pin(0, {1'b0, spss_pkg::SEL_PLL_LOCK});
    edges = host_edges;
    repeat (3) begin
      pll_lock <= 1'b1;
      repeat (6) @(posedge clk);
      check(32'(pins[0]), 32'h1);
      pll_lock <= 1'b0;
      repeat (6) @(posedge clk);
    end
    check(32'(host_edges - edges), 32'h3);
    pin(0, {1'b0, spss_pkg::SEL_ASYNC_DATA});
    repeat (6) begin
      rx_async <= 1'($urandom);
      repeat (3) @(posedge clk);
      check(32'(pins[0]), 32'(rx_async));
    end
    // unsupported code shows only the invert bit
    pin(0, {1'b1, 6'h20});
    repeat (2) @(posedge clk);
    check(32'(pins[0]), 32'h1);
    // serial run, both directions at once
    pin(1, {1'b0, spss_pkg::SEL_SER_CLK});
    pin(2, {1'b0, spss_pkg::SEL_SYNC_DATA});
    pattern <= $urandom;
    {rx_mode, tx_mode} <= 2'b11;
    apb(1'b1, spss_pkg::OFF_THRESH, 32'h0100_0000);
    edges = takes;
    repeat (2) @(posedge clk);
    ser_chk <= 1'b1;
    repeat (200) @(posedge clk);
    ser_chk <= 1'b0;
    check(32'(takes - edges > 23), 32'h1);
    results();
  end
endmodule // testbench
